// ==== verilog/smsc_core.sv ====
// full-duplex serial port, master or slave, one byte at a time, msb first
// assumes software access strobes are one-cycle pulses on clock_i; in slave mode the
// link logic runs on the far master's sck, which idles outside transfers
//
// Function
// - bytes shift msb first both directions
// - received byte replaces sent byte in shifter
// - four timings from polarity and phase
// - select from pin or software bit
// - master drives sck at six rates
// - master drives mosi, samples miso
// - low select as master clears master and enable
// - master data write loads shifter, starts
// - slave takes sck, drives miso, samples mosi
// - slave starts on first external clock
// - enable without master means slave mode
// - done flag and gated interrupt per byte
// - received byte copied to read buffer
// - master done clear: status then read
// - slave done clear: status then access
// - data writes blocked until status read or write
// - slave sck at most half core clock
// - eight clock pulses per byte
// - write during transfer sets collision, dropped
// - low select as master faults
// - byte with done set flags overrun
`timescale 1ns/1ps
module smsc_core (
  input wire logic clock_i,
  input wire logic resetn_i,
  // software side
  input wire logic ctrl_write_i,
  input wire smsc_pkg::smsc_ctrl_t ctrl_wdata_i,
  input wire logic status_read_i,
  input wire logic status_write_i,
  input wire logic data_read_i,
  input wire logic data_write_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic slave_select_source_i,
  input wire logic internal_slave_select_i,
  input wire logic cpu_irq_mask_i,
  output logic [7:0] data_rdata_o,
  output smsc_pkg::smsc_ctrl_t ctrl_o,
  output smsc_pkg::smsc_status_t status_o,
  output logic busy_o,
  output logic irq_o,
  // link pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic ss_n_i
);
  import smsc_pkg::*;

  typedef struct packed {
    smsc_ctrl_t ctrl;
    smsc_status_t st;
    logic csr_seen;
    logic [2:0] ss_sync;
    logic [2:0] miso_sync;
    logic [2:0] tgl_sync;
    logic ss_lvl;
    logic miso_lvl;
    logic tgl_lvl;
    smsc_state_t fsm;
    logic [7:0] shifter;
    logic [7:0] tx;
    logic [7:0] rx_buf;
    logic [8:0] div_cnt;
    logic [4:0] edge_cnt;
    logic samp_pend;
    logic [2:0] samp_cnt;
    logic sck;
    logic mosi;
  } smsc_core_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sr;
  } smsc_link_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a synchronised level only moves once stages two and three agree
  function automatic logic settle(input logic [2:0] sync, input logic old);
    settle = (sync[1] == sync[2]) ? sync[2] : old;
  endfunction

  // half period in core cycles; codes above the last rate reuse the slowest
  function automatic logic [8:0] half_period(input logic [2:0] code);
    logic [2:0] c;
    c = (code > RATE_CODE_MAX) ? RATE_CODE_MAX : code;
    half_period = HALF_PERIOD_MIN << c;
  endfunction

  smsc_core_t q;
  smsc_core_t d;
  smsc_link_t lq;
  smsc_link_t ld;
  logic [7:0] link_rx_q;
  logic link_tgl_q;
  logic ss_raw;
  logic slave_sel_raw;
  logic link_clk;
  logic link_rst_n;
  logic slave_mode;
  logic master_run;
  logic slave_busy;
  logic tgl_event;
  logic half_done;
  logic capture;
  logic finish;
  logic [7:0] done_byte;

  // ---------------------------------------------------------------
  // select source and link clock
  // ---------------------------------------------------------------
  // select source mux
  assign ss_raw = slave_select_source_i ? internal_slave_select_i : ss_n_i;
  assign slave_mode = q.ctrl.port_enable & ~q.ctrl.master_select;
  assign slave_sel_raw = slave_mode & ~ss_raw;
  // capture edge always rises here
  // polarity and phase are only changed with the port disabled, so the xor is static
  assign link_clk = sck_i ^ (q.ctrl.clock_polarity ^ q.ctrl.clock_phase);
  // deselect parks the bit counter, so every selected byte starts at its msb
  assign link_rst_n = resetn_i & slave_sel_raw;

  // ---------------------------------------------------------------
  // slave link logic, clocked by the far master's sck
  // ---------------------------------------------------------------
  // slave samples mosi
  always_comb begin
    ld = lq;
    ld.cnt = lq.cnt + 3'h1;
    ld.sr = {lq.sr[5:0], mosi_i};
  end

  // sck to half core
  // the link flops see every capture edge of sck directly; the core sees only the byte toggle and the finished byte in link_rx_q
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // the finished byte and its toggle survive deselect until the core has taken them
  // slave completes on eighth capture
  always_ff @(posedge link_clk or negedge resetn_i) begin
    if (!resetn_i) begin
      link_rx_q <= DATA_RESET;
      link_tgl_q <= 1'b0;
    end else if (slave_sel_raw && lq.cnt == 3'h7) begin
      link_rx_q <= {lq.sr, mosi_i};
      link_tgl_q <= ~link_tgl_q;
    end
  end

  // ---------------------------------------------------------------
  // core next state
  // ---------------------------------------------------------------
  assign master_run = (q.fsm == SMSC_RUN);
  assign slave_busy = slave_mode & ~q.ss_lvl;
  // a finished slave byte shows up as a settled toggle; the byte itself sits in
  // link_rx_q, which is stable long before the toggle has crossed
  assign tgl_event = (q.tgl_lvl != settle(q.tgl_sync, q.tgl_lvl));
  assign half_done = master_run && (q.div_cnt == half_period(q.ctrl.master_rate_select) - 9'h1);
  assign capture = (q.edge_cnt[0] == q.ctrl.clock_phase);
  assign finish = master_run && (q.edge_cnt == EDGES_PER_BYTE) && !q.samp_pend;
  assign done_byte = finish ? q.shifter : link_rx_q;

  always_comb begin
    d = q;
    // three-flop synchronisers, the first stage feeds only the second
    d.ss_sync = {q.ss_sync[1:0], ss_raw};
    d.miso_sync = {q.miso_sync[1:0], miso_i};
    d.tgl_sync = {q.tgl_sync[1:0], link_tgl_q};
    d.ss_lvl = settle(q.ss_sync, q.ss_lvl);
    d.miso_lvl = settle(q.miso_sync, q.miso_lvl);
    d.tgl_lvl = settle(q.tgl_sync, q.tgl_lvl);

    // clears first, so that a set in the same cycle wins below
    if ((status_read_i || status_write_i) &&
        (q.st.transfer_done_flag || q.st.write_collision_flag || q.st.mode_fault_flag)) begin
      d.csr_seen = 1'b1;
    end
    if (status_read_i) begin
      d.st.overrun_flag = 1'b0;
    end
    if (q.csr_seen && (data_read_i || data_write_i)) begin
      d.st.write_collision_flag = 1'b0;
      d.csr_seen = 1'b0;
      if (data_read_i || slave_mode) begin
        d.st.transfer_done_flag = 1'b0;
      end
    end

    // control write; enable and master stay off under a fault unless it is being cleared
    if (ctrl_write_i) begin
      d.ctrl = ctrl_wdata_i;
      if (q.st.mode_fault_flag && q.csr_seen) begin
        d.st.mode_fault_flag = 1'b0;
        d.csr_seen = 1'b0;
      end else if (q.st.mode_fault_flag) begin
        d.ctrl.port_enable = 1'b0;
        d.ctrl.master_select = 1'b0;
      end
    end

    // data write: blocked while done is unacknowledged, collides while busy
    if (data_write_i && !(q.st.transfer_done_flag && !q.csr_seen)) begin
      if (master_run || slave_busy) begin
        // the byte in flight is left alone; only the flag records the lost write
        // collision drops the write
        d.st.write_collision_flag = 1'b1;
      end else begin
        d.tx = data_wdata_i;
        if (q.ctrl.port_enable && q.ctrl.master_select) begin
          d.fsm = SMSC_RUN;
          d.shifter = data_wdata_i;
          d.mosi = data_wdata_i[7];
          d.div_cnt = '0;
          d.edge_cnt = '0;
          d.samp_pend = 1'b0;
          d.sck = q.ctrl.clock_polarity;
        end
      end
    end

    // master sequencer
    if (master_run) begin
      d.div_cnt = half_done ? 9'h000 : q.div_cnt + 9'h001;
      if (half_done && q.edge_cnt != EDGES_PER_BYTE) begin
        d.sck = ~q.sck;
        d.edge_cnt = q.edge_cnt + 5'h01;
        if (capture) begin
          d.samp_pend = 1'b1;
          d.samp_cnt = '0;
        end else begin
          d.mosi = q.shifter[7];
        end
      end
      // miso is taken only once its synchroniser has settled, which is why the
      // fastest half period must stay above the sample delay
      if (q.samp_pend) begin
        d.samp_cnt = q.samp_cnt + 3'h1;
        if (q.samp_cnt == SAMPLE_DELAY - 3'h1) begin
          d.shifter = {q.shifter[6:0], q.miso_lvl};
          d.samp_pend = 1'b0;
        end
      end
      if (finish) begin
        d.fsm = SMSC_IDLE;
      end
    end else begin
      d.sck = q.ctrl.clock_polarity;
    end

    if (finish || tgl_event) begin
      // next send is the received byte
      d.tx = done_byte;
      if (q.st.transfer_done_flag) begin
        d.st.overrun_flag = 1'b1;
      end else begin
        d.rx_buf = done_byte;
      end
      d.st.transfer_done_flag = 1'b1;
    end

    if (q.ctrl.port_enable && q.ctrl.master_select && !q.ss_lvl) begin
      d.st.mode_fault_flag = 1'b1;
      d.ctrl.port_enable = 1'b0;
      d.ctrl.master_select = 1'b0;
      d.fsm = SMSC_IDLE;
      d.samp_pend = 1'b0;
      d.sck = q.ctrl.clock_polarity;
    end
  end

  // ---------------------------------------------------------------
  // core state register
  // ---------------------------------------------------------------
  // select levels reset high so no fault is seen before the pin settles
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.ss_sync <= 3'h7;
      q.ss_lvl <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign data_rdata_o = q.rx_buf;
  assign ctrl_o = q.ctrl;
  assign status_o = q.st;
  assign busy_o = master_run | slave_busy;
  assign irq_o = q.ctrl.serial_irq_enable & ~cpu_irq_mask_i &
                 (q.st.transfer_done_flag | q.st.mode_fault_flag | q.st.overrun_flag);
  assign sck_o = q.sck;
  assign sck_oe_o = q.ctrl.port_enable & q.ctrl.master_select;
  assign mosi_o = q.mosi;
  assign mosi_oe_o = q.ctrl.port_enable & q.ctrl.master_select;
  // miso follows the link bit counter, so the msb stands as soon as select falls
  // slave drives miso msb first
  assign miso_o = q.tx[3'h7 - lq.cnt];
  assign miso_oe_o = slave_sel_raw;

endmodule

// ==== inc/smsc_pkg.sv ====
// package for the full-duplex serial port core: control fields, timing counts, state types
// assumes a 100 MHz core clock and a link clock that stands still outside transfers
package smsc_pkg;

  // ---------------------------------------------------------------
  // byte framing
  // ---------------------------------------------------------------
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10; // two sck edges per bit

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // a pin passes three flops plus the agreement stage before it is used
  localparam int unsigned SYNC_STAGES = 3;
  // master samples the synchronised miso this many cycles after a capture edge
  localparam logic [2:0] SAMPLE_DELAY = 3'h5;
  // shortest master half period in core cycles, must exceed SAMPLE_DELAY
  localparam logic [8:0] HALF_PERIOD_MIN = 9'h008;
  localparam logic [2:0] RATE_CODE_MAX = 3'h5; // six rates, codes 0..5
  localparam int unsigned MIN_SCK_PERIOD_NS = 2 * CLK_PERIOD_NS * 8;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  typedef struct packed {
    logic serial_irq_enable;
    logic port_enable;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic [2:0] master_rate_select;
  } smsc_ctrl_t;

  localparam smsc_ctrl_t CTRL_RESET = '0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // status flags as seen by software
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic overrun_flag;
  } smsc_status_t;

  // master transfer sequencer
  typedef enum logic {
    SMSC_IDLE,
    SMSC_RUN
  } smsc_state_t;

endpackage

// ==== verif/smsc_core_asserts.sv ====
// checker for the serial port core: pin enables, flags, interrupt, sck framing
// assumes only the core's ports and the single core clock domain
`timescale 1ns/1ps
module smsc_core_asserts (
  input logic clock_i,
  input logic resetn_i,
  input logic data_write_i,
  input logic data_read_i,
  input logic status_read_i,
  input logic slave_select_source_i,
  input logic internal_slave_select_i,
  input logic cpu_irq_mask_i,
  input logic ss_n_i,
  input smsc_pkg::smsc_ctrl_t ctrl_o,
  input smsc_pkg::smsc_status_t status_o,
  input logic busy_o,
  input logic irq_o,
  input logic sck_o,
  input logic sck_oe_o,
  input logic mosi_oe_o,
  input logic miso_oe_o
);
  import smsc_pkg::*;
  logic sel_n;
  logic sck_prev_q;
  logic [4:0] edge_cnt_q;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // effective select, high means not selected
  assign sel_n = slave_select_source_i ? internal_slave_select_i : ss_n_i;

  // sck toggles since the byte began, so a short or long byte shows up
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_prev_q <= 1'b0;
      edge_cnt_q <= 5'h00;
    end else begin
      sck_prev_q <= sck_o;
      if ($rose(busy_o))
        edge_cnt_q <= 5'h00;
      else if (sck_o != sck_prev_q)
        edge_cnt_q <= edge_cnt_q + 5'h01;
    end
  end

  mosi_en_a: assert property (sck_oe_o == mosi_oe_o
    && mosi_oe_o == (ctrl_o.port_enable & ctrl_o.master_select)) else $error("master enables");
  miso_en_a: assert property (miso_oe_o == (ctrl_o.port_enable & !ctrl_o.master_select
    & !sel_n)) else $error("slave enable");
  irq_gate_a: assert property (irq_o == (ctrl_o.serial_irq_enable & !cpu_irq_mask_i
    & (status_o.transfer_done_flag | status_o.mode_fault_flag | status_o.overrun_flag)))
    else $error("irq gating");
  sck_idle_a: assert property (!busy_o && mosi_oe_o && $stable(ctrl_o)
    |-> sck_o == ctrl_o.clock_polarity) else $error("sck idle level");
  write_collision_flag_set_a: assert property (data_write_i && busy_o && !status_o.transfer_done_flag
    |=> status_o.write_collision_flag) else $error("collision missed");
  mode_fault_a: assert property (mosi_oe_o && !sel_n |-> ##[1:8] (status_o.mode_fault_flag
    && !ctrl_o.port_enable && !ctrl_o.master_select)) else $error("mode fault");
  edge_count_a: assert property ($fell(busy_o) && ctrl_o.master_select
    |-> edge_cnt_q == EDGES_PER_BYTE) else $error("sck edge count");
  done_clear_a: assert property (status_read_i && status_o.transfer_done_flag
    && ctrl_o.master_select ##2 data_read_i && !busy_o |=> !status_o.transfer_done_flag)
    else $error("done not cleared");
endmodule

bind smsc_core smsc_core_asserts u_chk (
  .clock_i(clock_i),
  .resetn_i(resetn_i),
  .data_write_i(data_write_i),
  .data_read_i(data_read_i),
  .status_read_i(status_read_i),
  .slave_select_source_i(slave_select_source_i),
  .internal_slave_select_i(internal_slave_select_i),
  .cpu_irq_mask_i(cpu_irq_mask_i),
  .ss_n_i(ss_n_i),
  .ctrl_o(ctrl_o),
  .status_o(status_o),
  .busy_o(busy_o),
  .irq_o(irq_o),
  .sck_o(sck_o),
  .sck_oe_o(sck_oe_o),
  .mosi_oe_o(mosi_oe_o),
  .miso_oe_o(miso_oe_o)
);

// ==== verif/smsc_far_end.sv ====
// far-end model: a plain shift device that answers a master or plays master
// assumes the bench routes the free data line and the clock line through it
`timescale 1ns/1ps
module smsc_far_end (
  input wire logic act_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] tx_i,
  input wire logic sck_line_i,
  input wire logic din_i,
  output logic dout_o,
  output logic sck_o,
  output logic [7:0] rx_o
);
  logic [7:0] sr = 8'h00;
  logic [4:0] edges = 5'h00;
  logic tgl = 1'b0;

  assign sck_o = mode_i[1] ^ tgl;
  // a released line shows the inverse so a stale bit never passes
  assign dout_o = act_i ? sr[7] : ~sr[7];

  // a new frame loads the byte to send
  always @(posedge act_i) begin
    sr = tx_i;
    edges = 5'h00;
  end

  // msb first; odd edges capture for phase 0, even ones for phase 1
  always @(sck_line_i) begin
    if (act_i) begin
      edges = edges + 5'h01;
      if (edges[0] ^ mode_i[0])
        rx_o = {rx_o[6:0], din_i};
      else if (edges > 5'h01)
        sr = {sr[6:0], 1'b0};
    end
  end

  // clock only inside a frame, 160 ns period, off the core's phase
  task frame();
    #3;
    repeat (16) #80 tgl = ~tgl;
  endtask
endmodule

// ==== verif/tb.sv ====
// bench for the serial port core: master bytes at all rates and modes, overrun,
// mode fault and a slave byte against a far-end model; checker binds itself
`timescale 1ns/1ps
module tb;
  import smsc_pkg::*;
  logic clock_i, resetn_i, cpu_irq_mask_i, ss_n_i, sck_i, mosi_i, miso_i;
  logic slave_select_source_i, internal_slave_select_i, ctrl_write_i;
  logic status_read_i, status_write_i, data_read_i, data_write_i;
  logic busy_o, irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic p_act, p_dout, p_sck, done_q;
  logic [1:0] p_mode;
  logic [7:0] data_wdata_i, data_rdata_o, p_tx, p_rx, dat;
  logic [31:0] lfsr_q;
  logic [7:0] exp_q[$];
  smsc_ctrl_t ctrl_wdata_i, ctrl_o;
  smsc_status_t status_o;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc, hp;

  // each line carries whichever side drives it
  assign sck_i = sck_oe_o ? sck_o : p_sck;
  assign mosi_i = mosi_oe_o ? mosi_o : p_dout;
  assign miso_i = miso_oe_o ? miso_o : p_dout;

  smsc_core dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .ctrl_write_i(ctrl_write_i),
    .ctrl_wdata_i(ctrl_wdata_i), .status_read_i(status_read_i),
    .status_write_i(status_write_i), .data_read_i(data_read_i),
    .data_write_i(data_write_i), .data_wdata_i(data_wdata_i),
    .slave_select_source_i(slave_select_source_i),
    .internal_slave_select_i(internal_slave_select_i), .cpu_irq_mask_i(cpu_irq_mask_i),
    .data_rdata_o(data_rdata_o), .ctrl_o(ctrl_o), .status_o(status_o), .busy_o(busy_o),
    .irq_o(irq_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_i),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i)
  );
  smsc_far_end u_far (.act_i(p_act), .mode_i(p_mode), .tx_i(p_tx), .sck_line_i(sck_i),
    .din_i(mosi_oe_o ? mosi_i : miso_i), .dout_o(p_dout), .sck_o(p_sck), .rx_o(p_rx));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one-cycle strobes: ctrl write, data write, data read, status write, status read
  task automatic op(input logic [4:0] m, input logic [7:0] d);
    @(posedge clock_i);
    {ctrl_write_i, data_write_i, data_read_i, status_write_i, status_read_i} <= m;
    ctrl_wdata_i <= d;
    data_wdata_i <= d;
    @(posedge clock_i);
    {ctrl_write_i, data_write_i, data_read_i, status_write_i, status_read_i} <= 5'h00;
  endtask

  task automatic clr(input logic [4:0] acc, input logic [4:0] dat_acc);
    op(acc, 8'h00);
    op(dat_acc, 8'h00);
    @(posedge clock_i);
    check("flags cleared", {4'h0, status_o}, 8'h00);
  endtask

  // one byte each way; the far end answers or, for a slave byte, drives sck
  // a byte has ended once done or overrun moves away from its value at entry
  task automatic xfer(input logic [7:0] tx, input logic [7:0] far, input logic coll,
                      input logic slv, output int n);
    logic [1:0] st0;
    st0 = {status_o.transfer_done_flag, status_o.overrun_flag};
    n = 0;
    // the byte to send settles before the frame start loads it
    p_tx <= far;
    repeat (2) @(posedge clock_i);
    p_act <= 1'b1;
    exp_q.push_back(far);
    op(5'h08, tx);
    // select held low for a slave byte only, raised after
    ss_n_i <= !slv;
    if (coll) begin
      repeat (6) @(posedge clock_i);
      op(5'h08, ~tx);
    end
    if (slv)
      u_far.frame();
    while ({status_o.transfer_done_flag, status_o.overrun_flag} === st0 && n < 20000) begin
      @(posedge clock_i);
      n++;
    end
    check("byte done", {7'h00, n < 20000}, 8'h01);
    check("far end byte", p_rx, tx);
    if (coll)
      check("collision", status_o.write_collision_flag, 8'h01);
    @(posedge clock_i);
    p_act <= 1'b0;
    ss_n_i <= 1'b1;
    // a data write stays a collision until the raised select has crossed over
    repeat (5) @(posedge clock_i);
  endtask

  // oldest note is compared whenever a received byte is flagged
  always @(posedge clock_i) begin
    done_q <= status_o.transfer_done_flag;
    if (status_o.transfer_done_flag === 1'b1 && done_q !== 1'b1 && exp_q.size() > 0)
      check("rx buffer", data_rdata_o, exp_q.pop_front());
  end

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // the whole run needs under 20k cycles
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end

  initial begin
    resetn_i = 1'b0;
    {ctrl_write_i, data_write_i, data_read_i, status_write_i, status_read_i} = 5'h00;
    ctrl_wdata_i = CTRL_RESET;
    data_wdata_i = 8'h00;
    {slave_select_source_i, internal_slave_select_i, ss_n_i, cpu_irq_mask_i} = 4'he;
    {p_act, p_mode, p_tx} = 11'h000;
    lfsr_q = 32'h2406;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check("reset state", {status_o, ctrl_o[7:4]}, 8'h00);
    // six rates across the four timing modes, odd passes masked
    for (int i = 0; i < 6; i++) begin
      repeat (16) lfsr_q = lfsr(lfsr_q);
      p_mode <= i[1:0];
      op(5'h10, {3'b111, i[1:0], i[2:0]});
      xfer(lfsr_q[7:0], lfsr_q[15:8], i == 0, 1'b0, cyc);
      // sixteen half periods per byte, give or take the start and the last sample
      hp = int'(HALF_PERIOD_MIN) << (i + 4);
      check("byte length", {7'h00, cyc >= hp - 8 && cyc <= hp + 8}, 8'h01);
      cpu_irq_mask_i <= i[0];
      @(posedge clock_i);
      check("irq", irq_o, {7'h00, !i[0]});
      clr(5'h01, 5'h04);
    end
    // second byte lands while the first is unread
    cpu_irq_mask_i <= 1'b0;
    dat = lfsr_q[23:16];
    xfer(8'h3c, dat, 1'b0, 1'b0, cyc);
    op(5'h08, 8'h5a);
    @(posedge clock_i);
    check("write held", busy_o, 8'h00);
    op(5'h01, 8'h00);
    xfer(8'hc3, ~dat, 1'b0, 1'b0, cyc);
    void'(exp_q.pop_back());
    check("overrun", {7'h00, status_o.overrun_flag}, 8'h01);
    check("kept byte", data_rdata_o, dat);
    clr(5'h01, 5'h04);
    // select pin pulled low under an enabled master
    op(5'h10, 8'he0);
    slave_select_source_i <= 1'b0;
    ss_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    check("fault", {status_o.mode_fault_flag, ctrl_o[6:5], irq_o}, 8'h09);
    ss_n_i <= 1'b1;
    op(5'h01, 8'h00);
    op(5'h10, 8'hc0);
    p_mode <= 2'b00;
    @(posedge clock_i);
    check("slave setup", {status_o, ctrl_o[6:5]}, 8'h02);
    xfer(8'h96, 8'h5b, 1'b1, 1'b1, cyc);
    clr(5'h02, 5'h08);
    finish_test();
  end
endmodule
